// ==== hdl/emw_pkg.sv ====
// constants, types and helpers for the external memory wait/sector control
`default_nettype none
package emw_pkg;

   // -------------------------------------------------------------
   // register selection and field layout
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      EMW_SEL_ENSLP  = 2'h0,   // enable and sleep control
      EMW_SEL_SECTOR = 2'h1,   // sector wait control
      EMW_SEL_KEEPER = 2'h2    // keeper and mask control
   } emw_sel_e;

   localparam int unsigned EMW_IFACE_EN_BIT  = 7;
   localparam int unsigned EMW_UWAIT_LO_BIT  = 6;
   localparam int unsigned EMW_SLIM_LSB      = 4;
   localparam int unsigned EMW_LWAIT_LSB     = 2;
   localparam int unsigned EMW_UWAIT_HI_BIT  = 1;
   localparam int unsigned EMW_KEEP_BIT      = 7;
   localparam int unsigned EMW_HMASK_LSB     = 0;
   localparam logic [7:0]  EMW_ENSLP_WMASK   = 8'hff;
   localparam logic [7:0]  EMW_SECTOR_WMASK  = 8'h7e;
   localparam logic [7:0]  EMW_KEEPER_WMASK  = 8'h87;
   localparam logic [7:0]  EMW_REG_RESET     = 8'h00;

   // -------------------------------------------------------------
   // address map and timing
   // -------------------------------------------------------------
   localparam logic [15:0] EMW_EXT_BASE        = 16'h1100;
   localparam logic [15:0] EMW_EXT_BASE_LEGACY = 16'h1000;
   localparam int unsigned EMW_SECTOR_LSB      = 13;  // 0x2000 steps
   localparam logic [2:0]  EMW_HMASK_NONE      = 3'h7;
   localparam logic [1:0]  EMW_WAIT_HOLD       = 2'h3;
   localparam logic [1:0]  EMW_STRB_BASE_CYC   = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_STRB = 3'b010,
      ST_HOLD = 3'b011,
      ST_LAST = 3'b100
   } emw_state_e;

   // core load/store request
   typedef struct packed {
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } emw_acc_s;

   // ordinary port setting of an eight-pin group
   typedef struct packed {
      logic [7:0] val;
      logic [7:0] oe;
   } emw_port_s;

   // extra strobe cycles for a wait code
   function automatic logic [1:0] emw_extra(input logic [1:0] code);
      emw_extra = (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h2;
   endfunction

endpackage
`default_nettype wire

// ==== hdl/emw_pin_mux.sv ====
// alternate-function override of a group of port pins
`timescale 1ns/1ps
`default_nettype none
module emw_pin_mux #(
   parameter int unsigned W = 8
) (
   input  wire logic [W-1:0] alt_en_in,
   input  wire logic [W-1:0] alt_val_in,
   input  wire logic [W-1:0] alt_oe_in,
   input  wire logic [W-1:0] port_val_in,
   input  wire logic [W-1:0] port_oe_in,
   output logic      [W-1:0] pin_out,
   output logic      [W-1:0] pin_oe_out
);
   // refuse a width the logic cannot serve
   if (W < 1) begin : g_width_check
      $error("emw_pin_mux width must be at least one");
   end

   // per pin: alternate function wins over port direction
   assign pin_out    = (alt_en_in & alt_val_in) | (~alt_en_in & port_val_in);
   assign pin_oe_out = (alt_en_in & alt_oe_in) | (~alt_en_in & port_oe_in);
endmodule
`default_nettype wire

// ==== hdl/emw_ctrl.sv ====
// external memory interface: registers, sector wait select, pin control
`timescale 1ns/1ps
`default_nettype none
module emw_ctrl (
   input  wire logic              CLK_IN,
   input  wire logic              RST_IN,
   input  wire logic              LEGACY_MODE_IN,
   input  wire emw_pkg::emw_sel_e REG_SEL_IN,
   input  wire logic              REG_WE_IN,
   input  wire logic              REG_RE_IN,
   input  wire logic [7:0]        REG_WDATA_IN,
   output logic      [7:0]        REG_RDATA_OUT,
   input  wire logic              ACC_VALID_IN,
   input  wire emw_pkg::emw_acc_s ACC_IN,
   input  wire logic              NEXT_IS_DATA_IN,
   output logic                   ACC_READY_OUT,
   output logic                   ACC_DONE_OUT,
   output logic      [7:0]        ACC_RDATA_OUT,
   input  wire emw_pkg::emw_port_s PORT_AD_IN,
   input  wire emw_pkg::emw_port_s PORT_HI_IN,
   input  wire logic [2:0]        PORT_CTL_VAL_IN,
   input  wire logic [2:0]        PORT_CTL_OE_IN,
   input  wire logic [7:0]        AD_IN,
   output logic      [7:0]        AD_OUT,
   output logic      [7:0]        AD_OE_OUT,
   output logic      [7:0]        AD_PULLUP_OUT,
   output logic                   KEEPER_EN_OUT,
   output logic      [7:0]        KEEPER_VAL_OUT,
   output logic      [7:0]        HADDR_OUT,
   output logic      [7:0]        HADDR_OE_OUT,
   output logic                   ALE_OUT,
   output logic                   ALE_OE_OUT,
   output logic                   RD_N_OUT,
   output logic                   RD_N_OE_OUT,
   output logic                   WR_N_OUT,
   output logic                   WR_N_OE_OUT
);
   import emw_pkg::*;

   // -------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------
   logic [7:0] ensl_q, sect_q, keep_q, rdata_q;
   logic       iface_en, keep_bit;
   logic [2:0] slim, hmask;
   // writes keep reserved bits at zero
   // reserved bits zero
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ensl_q <= EMW_REG_RESET;
         sect_q <= EMW_REG_RESET;
         keep_q <= EMW_REG_RESET;
      end else if (REG_WE_IN) begin
         unique case (REG_SEL_IN)
            EMW_SEL_ENSLP:  ensl_q <= REG_WDATA_IN & EMW_ENSLP_WMASK;
            EMW_SEL_SECTOR: sect_q <= REG_WDATA_IN & EMW_SECTOR_WMASK;
            EMW_SEL_KEEPER: keep_q <= REG_WDATA_IN & EMW_KEEPER_WMASK;
            default: ;      // unmapped select ignored
         endcase
      end
   end
   // read data; extra registers are absent in legacy mode
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rdata_q <= 8'h00;
      end else if (REG_RE_IN) begin
         unique case (REG_SEL_IN)
            EMW_SEL_ENSLP:  rdata_q <= ensl_q;
            EMW_SEL_SECTOR: rdata_q <= LEGACY_MODE_IN ? 8'h00 : sect_q;
            EMW_SEL_KEEPER: rdata_q <= LEGACY_MODE_IN ? 8'h00 : keep_q;
            default:        rdata_q <= 8'h00;
         endcase
      end
   end
   assign REG_RDATA_OUT = rdata_q;
   // fields; legacy mode fixes sector, mask and keeper off
   assign iface_en = ensl_q[EMW_IFACE_EN_BIT];
   assign slim     = LEGACY_MODE_IN ? 3'h0 : sect_q[EMW_SLIM_LSB +: 3];
   assign hmask    = LEGACY_MODE_IN ? 3'h0 : keep_q[EMW_HMASK_LSB +: 3];
   assign keep_bit = keep_q[EMW_KEEP_BIT] & ~LEGACY_MODE_IN;

   // -------------------------------------------------------------
   // sector and wait selection at access start
   // -------------------------------------------------------------
   logic [15:0] ext_base, upper_start;
   logic        is_ext, is_upper;
   logic [1:0]  uwait, lwait, sel_wait;
   assign ext_base    = LEGACY_MODE_IN ? EMW_EXT_BASE_LEGACY : EMW_EXT_BASE;
   assign is_ext      = ACC_IN.addr >= ext_base;
   assign upper_start = {slim, 13'h0000};
   assign is_upper    = (slim == 3'h0) || (ACC_IN.addr >= upper_start);
   assign uwait = {sect_q[EMW_UWAIT_HI_BIT] & ~LEGACY_MODE_IN,
                   ensl_q[EMW_UWAIT_LO_BIT]};
   assign lwait = sect_q[EMW_LWAIT_LSB +: 2];
   assign sel_wait = !is_ext ? 2'h0 : (is_upper ? uwait : lwait);

   // -------------------------------------------------------------
   // access sequencer
   // -------------------------------------------------------------
   emw_state_e  state_q;
   logic [1:0]  cnt_q, code_q;
   logic        wr_q, ext_q, upper_q;
   logic [15:0] addr_q;
   logic [7:0]  wdata_q, rd_q;
   logic        take, strb_end;
   assign ACC_READY_OUT = (state_q == ST_IDLE) && iface_en;
   assign take          = ACC_VALID_IN && ACC_READY_OUT;
   assign strb_end      = (state_q == ST_STRB) && (cnt_q == 2'h0);
   // state walk: address, strobe, optional hold, final period
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: if (take) state_q <= ST_ADDR;
            ST_ADDR: state_q <= ST_STRB;
            ST_STRB: if (cnt_q == 2'h0) begin
               state_q <= (code_q == EMW_WAIT_HOLD) ? ST_HOLD : ST_LAST;
            end
            ST_HOLD: state_q <= ST_LAST;
            ST_LAST: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end
   // latch request; wait code frozen for the access
   // sector chosen at start
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         addr_q  <= 16'h0000;
         wdata_q <= 8'h00;
         wr_q    <= 1'b0;
         ext_q   <= 1'b0;
         upper_q <= 1'b0;
         code_q  <= 2'h0;
      end else if (take) begin
         addr_q  <= ACC_IN.addr;
         wdata_q <= ACC_IN.wdata;
         wr_q    <= ACC_IN.write;
         ext_q   <= is_ext;
         upper_q <= is_upper;
         code_q  <= sel_wait;
      end
   end
   // strobe counter: base two cycles plus extra ones
   // strobe stretch
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cnt_q <= 2'h0;
      end else if (state_q == ST_ADDR) begin
         cnt_q <= 2'(EMW_STRB_BASE_CYC - 2'h1 + emw_extra(code_q));
      end else if (state_q == ST_STRB && cnt_q != 2'h0) begin
         cnt_q <= cnt_q - 2'h1;
      end
   end
   // read data captured on the last strobe cycle
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rd_q <= 8'h00;
      end else if (strb_end && !wr_q) begin
         rd_q <= AD_IN;
      end
   end
   assign ACC_RDATA_OUT = rd_q;
   assign ACC_DONE_OUT  = (state_q == ST_LAST);

   // -------------------------------------------------------------
   // pin values
   // -------------------------------------------------------------
   logic       ale, rd_n, wr_n, ad_oe;
   logic [7:0] ad_val, hi_alt_en;
   logic [3:0] hi_used;
   assign ale    = (state_q == ST_ADDR) ||
                   ((state_q == ST_LAST) && NEXT_IS_DATA_IN);
   assign rd_n   = ~((state_q == ST_STRB) && ext_q && !wr_q);
   assign wr_n   = ~((state_q == ST_STRB) && ext_q && wr_q);
   assign ad_oe  = (state_q == ST_ADDR) || ((state_q == ST_STRB) && wr_q);
   assign ad_val = (state_q == ST_ADDR) ? addr_q[7:0] : wdata_q;
   assign hi_used   = (hmask == EMW_HMASK_NONE) ? 4'h0 : 4'(4'h8 - hmask);
   assign hi_alt_en = iface_en ? 8'(9'h0ff >> (4'h8 - hi_used)) : 8'h00;

   emw_pin_mux #(.W(8)) u_ad_mux (
      .alt_en_in   ({8{iface_en}}),
      .alt_val_in  (ad_val),
      .alt_oe_in   ({8{ad_oe}}),
      .port_val_in (PORT_AD_IN.val),
      .port_oe_in  (PORT_AD_IN.oe),
      .pin_out     (AD_OUT),
      .pin_oe_out  (AD_OE_OUT)
   );
   emw_pin_mux #(.W(8)) u_hi_mux (
      .alt_en_in   (hi_alt_en),
      .alt_val_in  (addr_q[15:8]),
      .alt_oe_in   (8'hff),
      .port_val_in (PORT_HI_IN.val),
      .port_oe_in  (PORT_HI_IN.oe),
      .pin_out     (HADDR_OUT),
      .pin_oe_out  (HADDR_OE_OUT)
   );

   emw_pin_mux #(.W(3)) u_ctl_mux (
      .alt_en_in   ({3{iface_en}}),
      .alt_val_in  ({wr_n, rd_n, ale}),
      .alt_oe_in   (3'h7),
      .port_val_in (PORT_CTL_VAL_IN),
      .port_oe_in  (PORT_CTL_OE_IN),
      .pin_out     ({WR_N_OUT, RD_N_OUT, ALE_OUT}),
      .pin_oe_out  ({WR_N_OE_OUT, RD_N_OE_OUT, ALE_OE_OUT})
   );
   assign AD_PULLUP_OUT = PORT_AD_IN.val & ~AD_OE_OUT;
   // keeper tracks the last level seen on the AD lines
   // hold last level
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         KEEPER_VAL_OUT <= 8'h00;
      end else begin
         KEEPER_VAL_OUT <= (AD_OE_OUT & AD_OUT) | (~AD_OE_OUT & AD_IN);
      end
   end
   assign KEEPER_EN_OUT = keep_bit;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   logic [2:0] strb_len_q;
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) strb_len_q <= 3'h0;
      else if (state_q == ST_STRB) strb_len_q <= strb_len_q + 3'h1;
      else strb_len_q <= 3'h0;
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   chk_pins_takeover: assert property (
      iface_en |-> (ALE_OE_OUT && RD_N_OE_OUT && WR_N_OE_OUT))
      else $error("strobe pins not taken over");
   chk_pins_release: assert property (
      !iface_en |-> (AD_OE_OUT == PORT_AD_IN.oe &&
                     HADDR_OE_OUT == PORT_HI_IN.oe))
      else $error("pins not released");
   chk_keeper_follow: assert property (
      (REG_WE_IN && REG_SEL_IN == EMW_SEL_KEEPER && !LEGACY_MODE_IN)
      |=> KEEPER_EN_OUT == $past(REG_WDATA_IN[7]))
      else $error("keeper enable wrong");
   chk_pullup_float: assert property (
      (state_q == ST_STRB && !wr_q && iface_en) |->
      AD_PULLUP_OUT == PORT_AD_IN.val)
      else $error("pull-up missing while floating");
   chk_sector_pick: assert property (
      (state_q == ST_ADDR && ext_q) |->
      upper_q == (slim == 3'h0 || addr_q >= {slim, 13'h0000}))
      else $error("sector choice wrong");
   chk_strobe_len: assert property (
      strb_end |-> strb_len_q == 3'(3'h1 + emw_extra(code_q)))
      else $error("strobe length wrong");
   chk_legacy_wait: assert property (
      (take && LEGACY_MODE_IN && is_ext) |=>
      code_q == {1'b0, ensl_q[EMW_UWAIT_LO_BIT]})
      else $error("legacy wait wrong");
   chk_reserved_zero: assert property (
      (REG_RE_IN && REG_SEL_IN == EMW_SEL_SECTOR) |=>
      (REG_RDATA_OUT[7] == 1'b0 && REG_RDATA_OUT[0] == 1'b0))
      else $error("reserved bit nonzero");
   chk_trail_ale: assert property (
      (state_q == ST_LAST && !NEXT_IS_DATA_IN) |-> !ALE_OUT)
      else $error("trailing latch pulse without data access");
   chk_addr_latch: assert property (
      (state_q == ST_ADDR && iface_en) |-> (ALE_OUT && AD_OE_OUT == 8'hff
      && AD_OUT == addr_q[7:0]) ##1 (!ALE_OUT && state_q == ST_STRB))
      else $error("address not valid at latch fall");
   chk_internal_quiet: assert property (
      (state_q != ST_IDLE && !ext_q) |-> (RD_N_OUT && WR_N_OUT))
      else $error("strobe during internal access");
   chk_hmask_none: assert property (
      (hmask == EMW_HMASK_NONE) |-> HADDR_OE_OUT == PORT_HI_IN.oe)
      else $error("high pins used under full mask");

   cov_ext_read: cover property (strb_end && ext_q && !wr_q);
   cov_ext_write_hold: cover property (state_q == ST_HOLD && wr_q);
   cov_lower_sector: cover property (state_q == ST_ADDR && ext_q && !upper_q);
endmodule
`default_nettype wire

// ==== dv/emw_sram_model.sv ====
// behavioural external sram reached through a transparent address latch
`timescale 1ns/1ps
`default_nettype none
module emw_sram_model #(
   parameter int SLOW_NS = 50
) (
   input  wire logic       ale_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic [7:0] haddr_in,
   input  wire logic [7:0] ad_in,
   input  wire logic       slow_in,
   output logic            drv_oe_out,
   output logic      [7:0] drv_val_out
);
   logic [7:0]  mem_q [logic [15:0]];
   logic [15:0] latch_q;
   wire logic [15:0] bus_late;

   // late copy models the latch hold time after its gate falls
   assign #1 bus_late = {haddr_in, ad_in};

   initial begin
      latch_q = 16'h0000;
      drv_oe_out = 1'b0;
      drv_val_out = 8'h00;
   end

   always @(negedge ale_in) latch_q = bus_late;

   always @(posedge wr_n_in) mem_q[latch_q] = bus_late[7:0];

   // data appears an access time after the read strobe falls
   always @(negedge rd_n_in) begin
      #(slow_in ? SLOW_NS : 5);
      if (rd_n_in === 1'b0) begin
         drv_val_out = mem_q.exists(latch_q) ? mem_q[latch_q] : 8'h00;
         drv_oe_out = 1'b1;
      end
   end

   // short data hold after the strobe ends, then the bus is let go
   always @(posedge rd_n_in) begin
      #2;
      drv_oe_out = 1'b0;
   end
endmodule
`default_nettype wire

// ==== dv/test_emw_ctrl.sv ====
// self-checking bench for the external memory wait and sector control
`timescale 1ns/1ps
`default_nettype none
module test_emw_ctrl;
   import emw_pkg::*;
   logic       clk, rst, legacy, reg_we, reg_re, acc_valid, next_data;
   logic       slow, acc_ready, acc_done, keep_en, ale, ale_oe;
   logic       rd_n, rd_oe, wr_n, wr_oe, sram_oe;
   emw_sel_e   reg_sel;
   logic [7:0] reg_wdata, reg_rdata, acc_rdata, ad_out, ad_oe, ad_pu;
   logic [7:0] keep_val, haddr, haddr_oe, ad_wire, float_q, sram_val;
   logic [2:0] ctl_val, ctl_oe;
   emw_acc_s   acc;
   emw_port_s  port_ad, port_hi;
   int         fail_count, tests_run;

   emw_ctrl emw_ctrl_inst (
      .CLK_IN(clk), .RST_IN(rst), .LEGACY_MODE_IN(legacy),
      .REG_SEL_IN(reg_sel), .REG_WE_IN(reg_we), .REG_RE_IN(reg_re),
      .REG_WDATA_IN(reg_wdata), .REG_RDATA_OUT(reg_rdata),
      .ACC_VALID_IN(acc_valid), .ACC_IN(acc), .NEXT_IS_DATA_IN(next_data),
      .ACC_READY_OUT(acc_ready), .ACC_DONE_OUT(acc_done),
      .ACC_RDATA_OUT(acc_rdata), .PORT_AD_IN(port_ad), .PORT_HI_IN(port_hi),
      .PORT_CTL_VAL_IN(ctl_val), .PORT_CTL_OE_IN(ctl_oe), .AD_IN(ad_wire),
      .AD_OUT(ad_out), .AD_OE_OUT(ad_oe), .AD_PULLUP_OUT(ad_pu),
      .KEEPER_EN_OUT(keep_en), .KEEPER_VAL_OUT(keep_val),
      .HADDR_OUT(haddr), .HADDR_OE_OUT(haddr_oe), .ALE_OUT(ale),
      .ALE_OE_OUT(ale_oe), .RD_N_OUT(rd_n), .RD_N_OE_OUT(rd_oe),
      .WR_N_OUT(wr_n), .WR_N_OE_OUT(wr_oe));

   emw_sram_model emw_sram_model_inst (
      .ale_in(ale), .rd_n_in(rd_n), .wr_n_in(wr_n), .haddr_in(haddr),
      .ad_in(ad_wire), .slow_in(slow), .drv_oe_out(sram_oe),
      .drv_val_out(sram_val));

   // wire level of the shared lines; a floating line changes every cycle
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ad_wire[i] = ad_oe[i] ? ad_out[i] : sram_oe ? sram_val[i] :
                      keep_en ? keep_val[i] : ad_pu[i] ? 1'b1 : float_q[i];
      end
   end

   always #10 clk = ~clk;
   always @(posedge clk) float_q <= ~float_q;

   task automatic check(string what, logic [15:0] got, logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   function automatic int xtra(logic [1:0] c);
      return (c == 2'h3) ? 2 : int'(c);
   endfunction

   task automatic reg_wr(emw_sel_e sel, logic [7:0] d);
      @(posedge clk);
      reg_sel <= sel;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask

   task automatic reg_rd(emw_sel_e sel, output logic [7:0] d);
      @(posedge clk);
      reg_sel <= sel;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask

   // one core access, timed and watched at the pins
   task automatic access(logic wr, logic [15:0] a, logic [7:0] wd,
                         logic nd, int cyc, int strb, output logic [7:0] rd);
      int n, lo;
      @(posedge clk);
      acc_valid <= 1'b1;
      acc <= '{write: wr, addr: a, wdata: wd};
      next_data <= nd;
      @(negedge clk);
      for (n = 0; n < 20 && acc_ready !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
      acc_valid <= 1'b0;
      @(negedge clk);
      check("addr phase ad", {ad_oe, ad_out}, {8'hff, a[7:0]});
      check("addr phase hi", {haddr, 7'h0, ale}, {a[15:8], 8'h01});
      lo = 0;
      for (n = 1; n < 20 && acc_done !== 1'b1; n++) begin
         lo += int'(rd_n === 1'b0) + int'(wr_n === 1'b0);
         @(negedge clk);
      end
      check("access cycles", 16'(n), 16'(cyc));
      check("strobe cycles", 16'(lo), 16'(strb));
      check("trailing latch", {15'h0, ale}, {15'h0, nd});
      rd = acc_rdata;
   endtask

   task automatic t_regs();
      logic [7:0] d;
      reg_rd(EMW_SEL_ENSLP, d);
      check("enable reset", {8'h0, d}, 16'h0000);
      reg_wr(EMW_SEL_SECTOR, 8'hff);
      reg_rd(EMW_SEL_SECTOR, d);
      check("sector reserved", {8'h0, d}, 16'h007e);
      reg_wr(EMW_SEL_KEEPER, 8'hff);
      reg_rd(EMW_SEL_KEEPER, d);
      check("keeper reserved", {8'h0, d}, 16'h0087);
      reg_wr(emw_sel_e'(2'h3), 8'hff);
      reg_rd(emw_sel_e'(2'h3), d);
      check("unmapped", {8'h0, d}, 16'h0000);
      reg_wr(EMW_SEL_SECTOR, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_pins();
      int u;
      reg_wr(EMW_SEL_KEEPER, 8'h80);
      @(negedge clk);
      check("keeper on", {15'h0, keep_en}, 16'h0001);
      check("port ad", {ad_out, ad_oe}, 16'h3c0f);
      check("pull ups", {8'h0, ad_pu}, 16'h0030);
      check("port hi", {haddr, haddr_oe}, port_hi);
      check("port ctl", {wr_n, rd_n, ale}, {13'h0, ctl_val});
      check("ctl oe", {wr_oe, rd_oe, ale_oe}, {13'h0, ctl_oe});
      check("ready off", {15'h0, acc_ready}, 16'h0000);
      reg_wr(EMW_SEL_KEEPER, 8'h00);
      reg_wr(EMW_SEL_ENSLP, 8'h80);
      @(negedge clk);
      check("keeper off", {15'h0, keep_en}, 16'h0000);
      check("strobe pins", {wr_oe, rd_oe, ale_oe, wr_n, rd_n}, 16'h1f);
      for (int m = 0; m < 8; m++) begin
         reg_wr(EMW_SEL_KEEPER, 8'(m));
         @(negedge clk);
         u = (m == 7) ? 0 : 8 - m;
         check("high mask", {8'h0, haddr_oe}, (16'h1 << u) - 16'h1);
      end
      reg_wr(EMW_SEL_KEEPER, 8'h00);
      $display("test pins done");
   endtask

   task automatic t_waits();
      logic [1:0] c;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         reg_wr(EMW_SEL_ENSLP, {1'b1, c[0], 6'h00});
         reg_wr(EMW_SEL_SECTOR, {6'h00, c[1], 1'b0});
         access(1'b1, 16'h1100 + 16'(i), 8'h3a + 8'(i), c[0],
                4 + xtra(c) + int'(c == 2'h3), 2 + xtra(c), d);
         access(1'b0, 16'h1100 + 16'(i), 8'h00, c[1],
                4 + xtra(c) + int'(c == 2'h3), 2 + xtra(c), d);
         check("read back", {8'h0, d}, {8'h0, 8'h3a + 8'(i)});
      end
      $display("test waits done");
   endtask

   task automatic t_sectors();
      logic [15:0] b;
      logic [7:0]  d;
      reg_wr(EMW_SEL_ENSLP, 8'hc0);
      for (int l = 0; l < 8; l++) begin
         reg_wr(EMW_SEL_SECTOR, {1'b0, 3'(l), 4'h6});
         b = (l == 0) ? 16'h1100 : 16'(l) << 13;
         access(1'b0, b, 8'h00, 1'b0, 7, 4, d);
         if (l > 0) begin
            access(1'b0, b - 16'h1, 8'h00, 1'b1, 5, 3, d);
         end
      end
      access(1'b0, 16'h0800, 8'h00, 1'b1, 4, 0, d);
      $display("test sectors done");
   endtask

   task automatic t_slow_legacy();
      logic [7:0] d;
      reg_wr(EMW_SEL_ENSLP, 8'h80);
      reg_wr(EMW_SEL_SECTOR, 8'h02);
      reg_wr(EMW_SEL_KEEPER, 8'h80);
      access(1'b1, 16'h4000, 8'h77, 1'b0, 6, 4, d);
      check("keeper hold", {8'h0, keep_val}, 16'h0077);
      reg_wr(EMW_SEL_KEEPER, 8'h00);
      slow <= 1'b1;
      access(1'b0, 16'h4000, 8'h00, 1'b0, 6, 4, d);
      check("slow read", {8'h0, d}, 16'h0077);
      slow <= 1'b0;
      @(posedge clk);
      legacy <= 1'b1;
      reg_wr(EMW_SEL_ENSLP, 8'hc0);
      reg_rd(EMW_SEL_SECTOR, d);
      check("legacy hidden", {8'h0, d}, 16'h0000);
      access(1'b0, 16'h1000, 8'h00, 1'b0, 5, 3, d);
      @(posedge clk);
      legacy <= 1'b0;
      $display("test slow legacy done");
   endtask

   initial begin
      #400us;
      fail_count++;
      report_and_stop();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {legacy, reg_we, reg_re, acc_valid, next_data, slow} = '0;
      reg_sel = EMW_SEL_ENSLP;
      reg_wdata = 8'h00;
      acc = '0;
      float_q = 8'h55;
      port_ad = '{val: 8'h3c, oe: 8'h0f};
      port_hi = '{val: 8'h96, oe: 8'h00};
      ctl_val = 3'b101;
      ctl_oe = 3'b010;
      fail_count = 0;
      tests_run = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_pins();
      t_waits();
      t_sectors();
      t_slow_legacy();
      report_and_stop();
   end
endmodule
`default_nettype wire
